// ===== ddci_core.sv
`timescale 1ns/1ps
`default_nettype none
module ddci_core
	import ddci_pkg::*;
#(
	parameter int RESET_HOLD_CYCLES = RESET_HOLD_CYC,
	parameter int CKE_WAIT_CYCLES   = CKE_WAIT_CYC,
	parameter int CKE_MIN_NCK       = DEF_CKE_MIN_NCK,
	parameter int XS_NCK            = DEF_XS_NCK,
	parameter int XSDLL_NCK         = DEF_XSDLL_NCK,
	parameter int DLLK_NCK          = DEF_DLLK_NCK,
	parameter int ZQINIT_NCK        = DEF_ZQINIT_NCK
) (
	input  wire logic             clk_sys,
	input  wire logic             reset,
	input  wire logic             dram_reset_n,
	input  wire logic             clk_en,
	input  wire logic             chip_sel_n,
	input  wire logic             row_strobe_n,
	input  wire logic             col_strobe_n,
	input  wire logic             write_en_n,
	input  wire logic [2:0]       bank_sel,
	input  wire logic             addr_a0,
	input  wire logic             addr_a8,
	input  wire logic             addr_a10,
	input  wire logic             termination_ctrl,
	input  wire logic             write_mask,
	input  wire logic             banks_open,
	input  wire logic             burst_active,
	input  wire logic [ERR_W-1:0] err_clear,
	output var  logic [3:0]       state_code,
	output var  logic             init_done,
	output var  logic             idle,
	output var  logic             power_down,
	output var  logic             precharge_pd,
	output var  logic             internal_refresh,
	output var  logic             termination_on,
	output var  logic             write_byte_en,
	output var  logic [ERR_W-1:0] err_flags
);
	localparam int XPR_NCK  = (XS_NCK > XPR_MIN_NCK) ? XS_NCK : XPR_MIN_NCK;
	localparam int LOCK_NCK = (DLLK_NCK > ZQINIT_NCK) ? DLLK_NCK : ZQINIT_NCK;
	localparam logic [CNT_W-1:0] RST_LIM   = CNT_W'(RESET_HOLD_CYCLES);
	localparam logic [CNT_W-1:0] WAIT_LIM  = CNT_W'(CKE_WAIT_CYCLES);
	localparam logic [CNT_W-1:0] PULSE_LIM = CNT_W'(CKE_MIN_NCK);
	localparam logic [CNT_W-1:0] SETUP_LIM = CNT_W'(CKE_SETUP_CYC);
	localparam logic [CNT_W-1:0] XPR_LIM   = CNT_W'(XPR_NCK);
	localparam logic [CNT_W-1:0] XS_LAST   = CNT_W'(XS_NCK - 1);
	localparam logic [CNT_W-1:0] XSDLL_LIM = CNT_W'(XSDLL_NCK);
	localparam logic [CNT_W-1:0] WR_LIM    = CNT_W'(WR_AFTER_SR_NCK);
	localparam logic [CNT_W-1:0] LOCK_LAST = CNT_W'(LOCK_NCK - 1);

	// Refuse timings the counters cannot hold
	if (RESET_HOLD_CYCLES < 1 || CKE_WAIT_CYCLES < 1 || CKE_MIN_NCK < 1 ||
		XS_NCK < 1 || XSDLL_NCK < 1 || LOCK_NCK < 1 ||
		RESET_HOLD_CYCLES >= 2**CNT_W || CKE_WAIT_CYCLES >= 2**CNT_W ||
		XSDLL_NCK >= 2**CNT_W || LOCK_NCK >= 2**CNT_W)
	begin : g_bad_timing
		$error("ddci_core: timing parameter out of range");
	end

	logic [PIN_W-1:0] pins_s;
	logic             rst_n_s;
	logic             cke_s;
	logic             cs_s;
	logic             ras_s;
	logic             cas_s;
	logic             we_s;
	logic [2:0]       ba_s;
	logic             a0_s;
	logic             a8_s;
	logic             a10_s;
	logic             odt_s;
	logic             wmask_s;

	// Pin inputs cross into the sampling clock
	ddci_sync #(
		.W (PIN_W)
	) u_pin_sync (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.async_in ({dram_reset_n, clk_en, chip_sel_n, row_strobe_n,
			col_strobe_n, write_en_n, bank_sel, addr_a0, addr_a8,
			addr_a10, termination_ctrl, write_mask}),
		.sync_out (pins_s)
	);
	assign {rst_n_s, cke_s, cs_s, ras_s, cas_s, we_s, ba_s,
		a0_s, a8_s, a10_s, odt_s, wmask_s} = pins_s;

	ddci_state_type   state_q, state_d;
	logic [CNT_W-1:0] tmr_q, tmr_d;
	logic [CNT_W-1:0] sr_q, sr_d;
	logic [CNT_W-1:0] hold_q, hold_d;
	logic             cke_prev_q, cke_prev_d;
	logic             prev_nop_q, prev_nop_d;
	logic             odt_ref_q, odt_ref_d;
	logic             init_done_q, init_done_d;
	logic             idle_q, idle_d;
	logic             pd_q, pd_d;
	logic             ppd_q, ppd_d;
	logic             iref_q, iref_d;
	logic             term_q, term_d;
	logic             wbe_q, wbe_d;
	logic [ERR_W-1:0] err_q, err_d;
	logic [ERR_W-1:0] set;
	ddci_cmd_type     cmd;
	logic             nop_like;
	logic             cke_fall;

	// Saturating count of clock edges
	function automatic logic [CNT_W-1:0] inc(input logic [CNT_W-1:0] v);
		return (&v) ? v : v + 1'b1;
	endfunction : inc

	// Mode load aimed at one mode word
	function automatic logic mode_ld(input ddci_cmd_type c,
		input logic [2:0] ba, input logic [2:0] want);
		return (c == CMD_MODE) && (ba == want);
	endfunction : mode_ld

	assign cmd      = ddci_decode(cs_s, ras_s, cas_s, we_s); // [RULE23]
	assign nop_like = (cmd == CMD_NOP) || (cmd == CMD_DES);
	assign cke_fall = cke_prev_q && !cke_s;

	// Next state, timers and error detection
	always_comb
	begin
		state_d    = state_q;
		tmr_d      = inc(tmr_q);
		sr_d       = inc(sr_q);
		hold_d     = (cke_s == cke_prev_q) ? inc(hold_q) : CNT_W'(1);
		odt_ref_d  = odt_ref_q;
		cke_prev_d = cke_s;
		prev_nop_d = nop_like;
		set        = '0;
		if (state_q != ST_RESET && cke_s != cke_prev_q && hold_q < PULSE_LIM)
			set[ERR_CKE_PULSE] = 1'b1; // [RULE1] [RULE26]
		if (state_q inside {ST_XPR, ST_MR3, ST_MR1, ST_MR0, ST_ZQ, ST_LOCK})
		begin
			if (!cke_s)
				set[ERR_CKE_DROP] = 1'b1; // [RULE17]
			if (odt_s != odt_ref_q)
				set[ERR_ODT_MOVE] = 1'b1; // [RULE19]
		end
		if (!rst_n_s)
		begin
			if (state_q != ST_RESET)
				tmr_d = '0;
			state_d = ST_RESET;
		end
		else
		begin
			case (state_q)
				ST_RESET:
				begin
					if (tmr_q < RST_LIM)
						set[ERR_RST_SHORT] = 1'b1; // [RULE13]
					if (cke_s || cke_prev_q || hold_q < SETUP_LIM)
						set[ERR_CKE_AT_REL] = 1'b1; // [RULE14]
					state_d = ST_WAIT;
					tmr_d   = '0;
				end
				ST_WAIT:
				begin
					if (cke_s)
					begin
						if (tmr_q < WAIT_LIM)
							set[ERR_CKE_EARLY] = 1'b1; // [RULE15]
						if (!prev_nop_q)
							set[ERR_NOP_FIRST] = 1'b1; // [RULE16]
						state_d   = ST_XPR;
						tmr_d     = '0;
						odt_ref_d = odt_s;
					end
				end
				ST_XPR:
				begin
					if (!nop_like)
					begin
						if (tmr_q < XPR_LIM)
							set[ERR_XPR_EARLY] = 1'b1; // [RULE20]
						if (mode_ld(cmd, ba_s, BA_MW2)) // [RULE24]
							state_d = ST_MR3; // [RULE21]
						else
							set[ERR_ORDER] = 1'b1;
					end
				end
				ST_MR3:
				begin
					if (!nop_like)
					begin
						if (mode_ld(cmd, ba_s, BA_MW3))
							state_d = ST_MR1; // [RULE21]
						else
							set[ERR_ORDER] = 1'b1;
					end
				end
				ST_MR1:
				begin
					if (!nop_like)
					begin
						if (mode_ld(cmd, ba_s, BA_MW1) && !a0_s)
							state_d = ST_MR0; // [RULE21]
						else
							set[ERR_ORDER] = 1'b1;
					end
				end
				ST_MR0:
				begin
					if (!nop_like)
					begin
						if (mode_ld(cmd, ba_s, BA_MW0) && a8_s)
							state_d = ST_ZQ; // [RULE21]
						else
							set[ERR_ORDER] = 1'b1;
					end
				end
				ST_ZQ:
				begin
					if (!nop_like)
					begin
						if (cmd == CMD_ZQ && a10_s)
						begin
							state_d = ST_LOCK; // [RULE22]
							tmr_d   = '0;
						end
						else
							set[ERR_ORDER] = 1'b1;
					end
				end
				ST_LOCK:
				begin
					if (!nop_like)
						set[ERR_ORDER] = 1'b1;
					if (tmr_q >= LOCK_LAST)
						state_d = ST_OPER; // [RULE22]
				end
				ST_OPER:
				begin
					if ((cmd == CMD_RD || odt_s) && sr_q < XSDLL_LIM)
						set[ERR_EARLY_RD] = 1'b1; // [RULE6]
					if (cmd == CMD_WR && sr_q < WR_LIM)
						set[ERR_EARLY_WR] = 1'b1; // [RULE7]
					if (cke_fall)
					begin
						if (nop_like) // [RULE3]
							state_d = banks_open ? ST_PD_ACT : ST_PD_PRE; // [RULE9]
						else if (cmd == CMD_REF)
						begin
							if (idle_q)
								state_d = ST_SR; // [RULE25]
							else
								set[ERR_SR_ENTRY] = 1'b1; // [RULE8]
						end
						else
							set[ERR_XCMD] = 1'b1; // [RULE3]
					end
				end
				ST_PD_PRE, ST_PD_ACT:
				begin
					if (cke_s)
					begin
						if (nop_like)
							state_d = ST_OPER;
						else
							set[ERR_XCMD] = 1'b1; // [RULE3]
					end
				end
				ST_SR:
				begin
					if (cke_s)
					begin
						if (nop_like)
						begin
							state_d = ST_SR_EXIT;
							sr_d    = '0;
						end
						else
							set[ERR_XCMD] = 1'b1; // [RULE5]
					end
				end
				ST_SR_EXIT:
				begin
					if (!nop_like)
						set[ERR_XCMD] = 1'b1; // [RULE5]
					if (!cke_s)
						set[ERR_ILLEGAL] = 1'b1; // [RULE2]
					if (sr_q >= XS_LAST)
						state_d = ST_OPER;
				end
				default:
				begin
					state_d          = ST_RESET;
					set[ERR_ILLEGAL] = 1'b1; // [RULE2]
				end
			endcase
		end
		err_d = (err_q & ~err_clear) | set;
		init_done_d = state_d inside {ST_OPER, ST_PD_PRE, ST_PD_ACT,
			ST_SR, ST_SR_EXIT};
		idle_d = (state_d == ST_OPER) && !banks_open && !burst_active &&
			cke_s; // [RULE10]
		pd_d   = state_d inside {ST_PD_PRE, ST_PD_ACT};
		ppd_d  = state_d == ST_PD_PRE;
		iref_d = state_d == ST_SR; // [RULE4]
		term_d = odt_s && !(state_d inside {ST_RESET, ST_WAIT, ST_SR}); // [RULE18] [RULE11]
		wbe_d  = !wmask_s; // [RULE12]
	end

	// Register all state and outputs
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			state_q     <= ST_RESET;
			tmr_q       <= '0;
			sr_q        <= '1;
			hold_q      <= '0;
			cke_prev_q  <= 1'b0;
			prev_nop_q  <= 1'b0;
			odt_ref_q   <= 1'b0;
			init_done_q <= 1'b0;
			idle_q      <= 1'b0;
			pd_q        <= 1'b0;
			ppd_q       <= 1'b0;
			iref_q      <= 1'b0;
			term_q      <= 1'b0;
			wbe_q       <= 1'b0;
			err_q       <= '0;
		end
		else
		begin
			state_q     <= state_d;
			tmr_q       <= tmr_d;
			sr_q        <= sr_d;
			hold_q      <= hold_d;
			cke_prev_q  <= cke_prev_d;
			prev_nop_q  <= prev_nop_d;
			odt_ref_q   <= odt_ref_d;
			init_done_q <= init_done_d;
			idle_q      <= idle_d;
			pd_q        <= pd_d;
			ppd_q       <= ppd_d;
			iref_q      <= iref_d;
			term_q      <= term_d;
			wbe_q       <= wbe_d;
			err_q       <= err_d;
		end
	end

	assign state_code       = state_q;
	assign init_done        = init_done_q;
	assign idle             = idle_q;
	assign power_down       = pd_q;
	assign precharge_pd     = ppd_q;
	assign internal_refresh = iref_q;
	assign termination_on   = term_q;
	assign write_byte_en    = wbe_q;
	assign err_flags        = err_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_oper_fall;
		rst_n_s && state_q == ST_OPER && cke_fall;
	endsequence
	sequence s_sr_entry;
		s_oper_fall ##0 (cmd == CMD_REF && idle_q);
	endsequence
	sequence s_pd_entry_act;
		s_oper_fall ##0 (nop_like && banks_open);
	endsequence

	a_sr_entry_idle: assert property (s_sr_entry |=> state_q == ST_SR) // [RULE25]
		else $error("self refresh not entered");
	a_pd_kind_act: assert property (s_pd_entry_act |=> state_q == ST_PD_ACT) // [RULE9]
		else $error("wrong power-down kind");
	a_sr_busy_ref: assert property (s_oper_fall ##0 (cmd == CMD_REF && !idle_q)
		|=> err_q[ERR_SR_ENTRY] && state_q == ST_OPER) // [RULE8]
		else $error("busy self refresh entry not flagged");
	a_sr_exit_len: assert property (state_q == ST_SR_EXIT |-> sr_q < XS_LAST + 1'b1) // [RULE5]
		else $error("self refresh exit overran");
	a_sr_exit_cmd: assert property (rst_n_s && state_q == ST_SR_EXIT &&
		!nop_like |=> err_q[ERR_XCMD]) // [RULE5]
		else $error("bad command in exit not flagged");
	a_pd_no_refresh: assert property (power_down |-> !internal_refresh) // [RULE4]
		else $error("refresh during power-down");
	a_odt_hiz: assert property (state_q inside {ST_RESET, ST_WAIT, ST_SR}
		|-> !termination_on) // [RULE18]
		else $error("termination on while forbidden");
	a_mask_inhibit: assert property (wmask_s |=> !write_byte_en) // [RULE12]
		else $error("masked byte enabled");
	a_lock_wait: assert property ($rose(init_done_q) |->
		$past(state_q) == ST_LOCK && $past(tmr_q) >= LOCK_LAST) // [RULE22]
		else $error("init done before lock wait");
	a_err_sticky: assert property ((|(err_q & ~err_clear)) |=> |err_q) // [RULE26]
		else $error("error flag lost");
	a_order_mr3: assert property (rst_n_s && state_q == ST_MR3 &&
		mode_ld(cmd, ba_s, BA_MW3) |=> state_q == ST_MR1) // [RULE21]
		else $error("mode word order not followed");
endmodule : ddci_core
`default_nettype wire

// ===== ddci_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ddci_core_tb_top
	import ddci_pkg::*;
;
	logic             clk_sys;
	logic             reset;
	logic             dram_reset_n, clk_en, chip_sel_n, row_strobe_n;
	logic             col_strobe_n, write_en_n, termination_ctrl;
	logic             addr_a0, addr_a8, addr_a10;
	logic [2:0]       bank_sel;
	logic             write_mask, banks_open, burst_active;
	logic [ERR_W-1:0] err_clear;
	logic [3:0]       state_code;
	logic             init_done, idle, power_down, precharge_pd;
	logic             internal_refresh, termination_on, write_byte_en;
	logic [ERR_W-1:0] err_flags;
	logic [31:0]      r;
	int               n_fail = 0;
	int               checks = 0;
	int               cycles = 0;

	ddci_core #(.RESET_HOLD_CYCLES(20), .CKE_WAIT_CYCLES(30),
		.CKE_MIN_NCK(3), .XS_NCK(10), .XSDLL_NCK(16), .DLLK_NCK(16),
		.ZQINIT_NCK(16)) ddci_core_inst (.clk_sys(clk_sys), .reset(reset),
		.dram_reset_n(dram_reset_n), .clk_en(clk_en),
		.chip_sel_n(chip_sel_n), .row_strobe_n(row_strobe_n),
		.col_strobe_n(col_strobe_n), .write_en_n(write_en_n),
		.bank_sel(bank_sel), .addr_a0(addr_a0), .addr_a8(addr_a8),
		.addr_a10(addr_a10), .termination_ctrl(termination_ctrl),
		.write_mask(write_mask), .banks_open(banks_open),
		.burst_active(burst_active), .err_clear(err_clear),
		.state_code(state_code), .init_done(init_done), .idle(idle),
		.power_down(power_down), .precharge_pd(precharge_pd),
		.internal_refresh(internal_refresh),
		.termination_on(termination_on), .write_byte_en(write_byte_en),
		.err_flags(err_flags));

	ddci_ctrl_model ddci_ctrl_model_inst (.clk_sys(clk_sys),
		.dram_reset_n(dram_reset_n), .clk_en(clk_en),
		.chip_sel_n(chip_sel_n), .row_strobe_n(row_strobe_n),
		.col_strobe_n(col_strobe_n), .write_en_n(write_en_n),
		.bank_sel(bank_sel), .addr_a0(addr_a0), .addr_a8(addr_a8),
		.addr_a10(addr_a10), .termination_ctrl(termination_ctrl));

	// 100 MHz clock
	initial clk_sys = 1'b0;
	always #5 clk_sys = ~clk_sys;

	// Hang guard
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			n_fail++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("Counts: %0d checks, %0d failures", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	task automatic check(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : check

	// Let n edges pass, then look after their updates
	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : settle

	// Bounded wait for a state code
	task automatic wait_state(input logic [3:0] exp, input int lim);
		int k;
		k = 0;
		while (state_code !== exp && k < lim)
		begin
			settle(1);
			k++;
		end
		check(state_code === exp, "state code not reached");
	endtask : wait_state

	// Sticky error check, then clear them all
	task automatic err_seen(input int pos, input string msg);
		settle(4);
		check(err_flags[pos] === 1'b1, msg);
		@(posedge clk_sys);
		err_clear <= '1;
		@(posedge clk_sys);
		err_clear <= '0;
		settle(2);
		check(err_flags === '0, "error flags not cleared");
	endtask : err_seen

	initial
	begin
		reset = 1'b1;
		write_mask = 1'b0;
		banks_open = 1'b0;
		burst_active = 1'b0;
		err_clear = '0;
		r = $urandom(32'ha011);
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		settle(3);
		check(state_code === 4'h0, "state while pin reset low");
		check(termination_on === 1'b0, "termination in reset");
		ddci_ctrl_model_inst.power_up(25);
		wait_state(ST_OPER, 40);
		check(init_done === 1'b1, "init not done");
		check(err_flags === '0, "errors after clean init");
		$display("Test power_up done");
		// All eight combinations first, then random ones
		for (int i = 0; i < 14; i++)
		begin
			@(posedge clk_sys);
			r = (i < 8) ? i : $urandom;
			write_mask <= r[0];
			banks_open <= r[1];
			burst_active <= r[2];
			settle(4);
			check(write_byte_en === ~r[0], "write mask");
			check(idle === ~(r[1] | r[2]), "idle level");
		end
		$display("Test mask_idle done");
		// Precharge then active power-down
		for (int b = 0; b < 2; b++)
		begin
			@(posedge clk_sys);
			banks_open <= b[0];
			burst_active <= 1'b0;
			settle(4);
			ddci_ctrl_model_inst.pause(4, 1'b0);
			settle(3);
			check(state_code === (b ? ST_PD_ACT : ST_PD_PRE), "pd kind");
			check(precharge_pd === ~b[0], "pd flag");
			check(power_down === 1'b1, "power down");
			check(internal_refresh === 1'b0, "refresh in pd");
			ddci_ctrl_model_inst.pause(4, 1'b1);
			wait_state(ST_OPER, 8);
		end
		$display("Test power_down done");
		@(posedge clk_sys);
		banks_open <= 1'b0;
		settle(4);
		ddci_ctrl_model_inst.term(1'b1);
		settle(4);
		check(termination_on === 1'b1, "termination off in idle");
		ddci_ctrl_model_inst.send(1'b0, CMD_REF, 3'h0, 3'h0);
		ddci_ctrl_model_inst.pause(5, 1'b0);
		settle(1);
		check(state_code === ST_SR, "sr entry");
		check(internal_refresh === 1'b1, "sr refresh");
		check(termination_on === 1'b0, "termination in sr");
		ddci_ctrl_model_inst.pause(1, 1'b1);
		wait_state(ST_SR_EXIT, 5);
		wait_state(ST_OPER, 14);
		ddci_ctrl_model_inst.send(1'b1, CMD_WR, 3'h0, 3'h0);
		ddci_ctrl_model_inst.pause(1, 1'b1);
		ddci_ctrl_model_inst.term(1'b0);
		settle(2);
		check(err_flags[ERR_EARLY_WR] === 1'b1, "early write");
		err_seen(ERR_EARLY_RD, "termination before lock");
		check(err_flags === '0, "write flag cleared");
		ddci_ctrl_model_inst.pause(520, 1'b1);
		ddci_ctrl_model_inst.send(1'b1, CMD_WR, 3'h0, 3'h0);
		settle(4);
		check(err_flags === '0, "late write flagged");
		// Command other than no-op inside the self-refresh exit period
		ddci_ctrl_model_inst.send(1'b0, CMD_REF, 3'h0, 3'h0);
		ddci_ctrl_model_inst.pause(5, 1'b0);
		ddci_ctrl_model_inst.pause(3, 1'b1);
		ddci_ctrl_model_inst.send(1'b1, CMD_PRE, 3'h0, 3'h0);
		ddci_ctrl_model_inst.pause(1, 1'b1);
		err_seen(ERR_XCMD, "command in sr exit");
		wait_state(ST_OPER, 12);
		$display("Test self_refresh done");
		ddci_ctrl_model_inst.send(1'b0, CMD_ACT, 3'h0, 3'h0);
		ddci_ctrl_model_inst.pause(3, 1'b0);
		ddci_ctrl_model_inst.pause(4, 1'b1);
		err_seen(ERR_XCMD, "bad command at pd entry");
		ddci_ctrl_model_inst.pause(1, 1'b0);
		ddci_ctrl_model_inst.pause(4, 1'b1);
		err_seen(ERR_CKE_PULSE, "short enable pulse");
		@(posedge clk_sys);
		burst_active <= 1'b1;
		settle(4);
		ddci_ctrl_model_inst.send(1'b0, CMD_REF, 3'h0, 3'h0);
		ddci_ctrl_model_inst.pause(3, 1'b0);
		ddci_ctrl_model_inst.pause(4, 1'b1);
		burst_active <= 1'b0;
		err_seen(ERR_SR_ENTRY, "sr entry in burst");
		wait_state(ST_OPER, 20);
		ddci_ctrl_model_inst.power_up(5);
		settle(2);
		check(err_flags[ERR_RST_SHORT] === 1'b1, "short pin reset");
		$display("Test faults done");
		give_verdict();
	end
endmodule : ddci_core_tb_top
`default_nettype wire

// ===== ddci_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// Memory controller side: drives reset, enable, commands, termination
module ddci_ctrl_model
	import ddci_pkg::*;
(
	input  wire logic       clk_sys,
	output var  logic       dram_reset_n,
	output var  logic       clk_en,
	output var  logic       chip_sel_n,
	output var  logic       row_strobe_n,
	output var  logic       col_strobe_n,
	output var  logic       write_en_n,
	output var  logic [2:0] bank_sel,
	output var  logic       addr_a0,
	output var  logic       addr_a8,
	output var  logic       addr_a10,
	output var  logic       termination_ctrl
);
	// Pins at time zero: device held in reset, enable low
	initial
	begin
		dram_reset_n = 1'b0;
		clk_en = 1'b0;
		{chip_sel_n, row_strobe_n, col_strobe_n, write_en_n} = 4'hf;
		bank_sel = 3'h0;
		{addr_a10, addr_a8, addr_a0} = 3'h0;
		termination_ctrl = 1'b0;
	end

	// One command on one edge; lines of a deselected device keep moving
	task automatic send(input logic c, input ddci_cmd_type cmd,
		input logic [2:0] ba, input logic [2:0] adr);
		logic       des;
		logic [8:0] junk;
		des  = (cmd == CMD_DES);
		junk = 9'($urandom);
		@(posedge clk_sys);
		clk_en <= c;
		chip_sel_n <= des;
		bank_sel <= des ? junk[2:0] : ba;
		{row_strobe_n, col_strobe_n, write_en_n} <=
			des ? junk[5:3] : cmd[2:0];
		{addr_a10, addr_a8, addr_a0} <= des ? junk[8:6] : adr;
	endtask : send

	// No-operation or deselect, drawn at random, for n edges
	task automatic pause(input int n, input logic c);
		repeat (n)
			send(c, ($urandom & 1) ? CMD_DES : CMD_NOP, 3'h0, 3'h0);
	endtask : pause

	// Termination level change on an edge
	task automatic term(input logic t);
		@(posedge clk_sys);
		termination_ctrl <= t;
	endtask : term

	// Whole power-up, pin reset held for hold edges
	task automatic power_up(input int hold);
		send(1'b0, CMD_NOP, 3'h0, 3'h0);
		dram_reset_n <= 1'b0;
		termination_ctrl <= 1'b0;
		pause(hold, 1'b0);
		dram_reset_n <= 1'b1;
		pause(35, 1'b0);
		pause(14, 1'b1);
		send(1'b1, CMD_MODE, BA_MW2, 3'h0);
		pause(4, 1'b1);
		send(1'b1, CMD_MODE, BA_MW3, 3'h0);
		pause(4, 1'b1);
		send(1'b1, CMD_MODE, BA_MW1, 3'h0);
		pause(4, 1'b1);
		send(1'b1, CMD_MODE, BA_MW0, 3'h2);
		pause(4, 1'b1);
		send(1'b1, CMD_ZQ, 3'h0, 3'h4);
		pause(24, 1'b1);
	endtask : power_up
endmodule : ddci_ctrl_model
`default_nettype wire

// ===== ddci_pkg_sync.sv
// Notes on behaviour
// (RULE1) Clock enable held for minimum pulse edges
// (RULE2) Unlisted state and enable sequences are unsupported
// (RULE3) Power-down entry or exit needs deselect/no-op
// (RULE4) No internal refresh while in power-down
// (RULE5) Only deselect/no-op during self-refresh exit period
// (RULE6) Reads and termination wait for lock exit time
// (RULE7) First write waits 512 cycles after exit
// (RULE8) Self refresh only from all-banks-idle state
// (RULE9) Closed banks give precharge power-down, else active
// (RULE10) Idle: banks closed, no burst, enable high
// (RULE11) Termination ignored by transitions, off in self refresh
// (RULE12) Write mask low writes byte, high inhibits
// (RULE13) Reset held at least 200 us
// (RULE14) Clock enable low 10 ns before reset release
// (RULE15) Wait 500 us after reset before enable
// (RULE16) Stable clock and no-op before enable rises
// (RULE17) Enable stays high until initialisation ends
// (RULE18) Termination high impedance until enable first high
// (RULE19) Termination input static during initialisation
// (RULE20) Reset exit time before first mode load
// (RULE21) Mode words loaded in order 2,3,1,0
// (RULE22) Long calibration, then lock and calibration wait
// (RULE23) Commands decoded from strobes at rising edge
// (RULE24) Mode load is all strobes low
// (RULE25) Refresh with enable falling enters self refresh
// (RULE26) Flag commands arriving in forbidden states
`timescale 1ns/1ps
`default_nettype none
package ddci_pkg;
	localparam int CLK_PERIOD_NS      = 10;
	localparam int T_RESET_HOLD_US    = 200;
	localparam int T_CKE_WAIT_US      = 500;
	localparam int T_CKE_SETUP_NS     = 10;
	localparam int RESET_HOLD_CYC     =
		(T_RESET_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CKE_WAIT_CYC       =
		(T_CKE_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CKE_SETUP_CYC_RAW  =
		(T_CKE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CKE_SETUP_CYC      =
		(CKE_SETUP_CYC_RAW < 1) ? 1 : CKE_SETUP_CYC_RAW;
	localparam int XPR_MIN_NCK        = 5;
	localparam int WR_AFTER_SR_NCK    = 512;
	// Plain defaults for timings given elsewhere
	localparam int DEF_CKE_MIN_NCK    = 3;
	localparam int DEF_XS_NCK         = 100;
	localparam int DEF_XSDLL_NCK      = 512;
	localparam int DEF_DLLK_NCK       = 512;
	localparam int DEF_ZQINIT_NCK     = 512;
	localparam int CNT_W              = 20;
	localparam int PIN_W              = 14;
	// Bank select codes of the mode words
	localparam logic [2:0] BA_MW0     = 3'h0;
	localparam logic [2:0] BA_MW1     = 3'h1;
	localparam logic [2:0] BA_MW2     = 3'h2;
	localparam logic [2:0] BA_MW3     = 3'h3;
	// Sticky error flag positions
	localparam int ERR_RST_SHORT      = 0;
	localparam int ERR_CKE_AT_REL     = 1;
	localparam int ERR_CKE_EARLY      = 2;
	localparam int ERR_CKE_PULSE      = 3;
	localparam int ERR_XCMD           = 4;
	localparam int ERR_ORDER          = 5;
	localparam int ERR_CKE_DROP       = 6;
	localparam int ERR_ODT_MOVE       = 7;
	localparam int ERR_EARLY_RD       = 8;
	localparam int ERR_EARLY_WR       = 9;
	localparam int ERR_SR_ENTRY       = 10;
	localparam int ERR_ILLEGAL        = 11;
	localparam int ERR_NOP_FIRST      = 12;
	localparam int ERR_XPR_EARLY      = 13;
	localparam int ERR_W              = 14;

	typedef enum logic [3:0] {
		ST_RESET   = 4'h0,
		ST_WAIT    = 4'h1,
		ST_XPR     = 4'h2,
		ST_MR3     = 4'h3,
		ST_MR1     = 4'h4,
		ST_MR0     = 4'h5,
		ST_ZQ      = 4'h6,
		ST_LOCK    = 4'h7,
		ST_OPER    = 4'h8,
		ST_PD_PRE  = 4'h9,
		ST_PD_ACT  = 4'hA,
		ST_SR      = 4'hB,
		ST_SR_EXIT = 4'hC
	} ddci_state_type;

	typedef enum logic [3:0] {
		CMD_MODE = 4'h0,
		CMD_REF  = 4'h1,
		CMD_PRE  = 4'h2,
		CMD_ACT  = 4'h3,
		CMD_WR   = 4'h4,
		CMD_RD   = 4'h5,
		CMD_ZQ   = 4'h6,
		CMD_NOP  = 4'h7,
		CMD_DES  = 4'h8
	} ddci_cmd_type;

	// Command from the four strobes at one edge
	function automatic ddci_cmd_type ddci_decode(
		input logic cs_n,
		input logic ras_n,
		input logic cas_n,
		input logic we_n
	);
		if (cs_n)
			return CMD_DES;
		return ddci_cmd_type'({1'b0, ras_n, cas_n, we_n});
	endfunction : ddci_decode
endpackage : ddci_pkg

// Two-stage synchroniser for pin inputs
module ddci_sync
	import ddci_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         reset,
	input  wire logic [W-1:0] async_in,
	output var  logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	// First stage feeds only the second
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			meta_q   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : ddci_sync
`default_nettype wire
